// ---- hw/phy_test_pkg.sv ----
package phy_test_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 25;
   // Settling time between a power-down request and the ready flag.
   localparam int PD_SETTLE_NS = 100;
   // A least time, so it rounds up to whole cycles.
   localparam int PD_SETTLE_CYC = (PD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************************************
   // Test pattern control word layout
   // ****************************************************************
   localparam int SEL_MSB = 15;
   localparam int SEL_LSB = 13;
   localparam logic [2:0] SEL_NORMAL = 3'h0;
   localparam logic [2:0] SEL_PAT1 = 3'h1;
   localparam logic [2:0] SEL_PAT2 = 3'h2;
   localparam logic [2:0] SEL_PAT3 = 3'h3;

   // ****************************************************************
   // Ternary line symbols and pattern lengths
   // ****************************************************************
   localparam logic [1:0] SYM_ZERO = 2'h0;
   localparam logic [1:0] SYM_PLUS = 2'h1;
   localparam logic [1:0] SYM_MINUS = 2'h3;
   localparam logic [4:0] PAT2_HALF = 5'h0A;
   localparam logic [4:0] PAT2_LEN = 5'h14;

   // ****************************************************************
   // Power-down sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      PD_RUN = 3'b001,
      PD_ENTERING = 3'b010,
      PD_DOWN = 3'b100
   } pd_state_type;

endpackage

// ---- hw/phy_test_mode.sv ----
`timescale 1ns/100ps
// Functional notes
// - Each PHY instance holds its own mode state, untouched by the other PHY.
// - Select field bits 15:13; 001, 010, 011 pick patterns one to three.
// - Pattern one sends plus one, minus one, alternating forever.
// - Pattern two sends ten plus ones then ten minus ones, repeating.
// - Pattern three transmits normally as master, sending only interframe idle.
// - Patterns replace only transmit data symbols; timing and receive unchanged.
// - Transmit-disable keeps both paths normal but forces every symbol to zero.
// - Host polls the ready flag; device raises it once power-down is reached.
// - Originating PHY sends frame-generator frames onto the cable.
// - With remote loopback on, frames from the line go back out the line.
// - Frame checker examines frames from the line, counting frames and errors.
// - While the generator is active, MAC transmit data is ignored.
// - With remote loopback on and receive suppress set, line frames do not reach the internal MAC.
module phy_test_mode #(
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic soft_powerdown_request,
   output logic soft_powerdown_ready_flag,
   input wire logic autoneg_enable_bit,
   input wire logic autoneg_forced_mode_bit,
   input wire logic [15:0] test_pattern_control_reg,
   input wire logic tx_disable_mode_bit,
   input wire logic remote_loopback_enable,
   input wire logic remote_loopback_rx_suppress,
   input wire logic gen_active,
   input wire logic [3:0] gen_txd,
   input wire logic gen_tx_en,
   input wire logic [3:0] mac_txd,
   input wire logic mac_tx_en,
   input wire logic [3:0] line_rxd,
   input wire logic line_rx_dv,
   input wire logic line_rx_er,
   output logic [3:0] mac_rxd,
   output logic mac_rx_dv,
   output logic [3:0] pcs_txd,
   output logic pcs_tx_en,
   input wire logic sym_strobe,
   input wire logic [1:0] pcs_sym,
   output logic [1:0] tx_sym,
   output logic [2:0] active_pattern,
   output logic active_tx_disable,
   input wire logic checker_enable,
   output logic [CNT_W-1:0] checker_frame_count,
   output logic [CNT_W-1:0] checker_error_count
);

   // ****************************************************************
   // State record
   // ****************************************************************
   typedef struct packed {
      phy_test_pkg::pd_state_type pd_state;
      logic [3:0] settle_cnt;
      logic [2:0] mode;
      logic txdis;
      logic [4:0] pat2_idx;
      logic [1:0] sym;
      logic [3:0] txd;
      logic tx_en;
      logic [3:0] rxd;
      logic rx_dv;
      logic in_frame;
      logic frame_bad;
      logic [CNT_W-1:0] frm_cnt;
      logic [CNT_W-1:0] err_cnt;
   } phy_state_type;

   phy_state_type st_ff;
   phy_state_type nxt_st;
   logic [2:0] req_mode;
   logic [1:0] pat_sym;
   // Last index of the twenty-symbol droop pattern.
   localparam logic [4:0] PAT2_LAST = phy_test_pkg::PAT2_LEN - 5'h1;

   // Forced link is required for a test mode; otherwise normal data runs.
   always_comb begin
      if (!autoneg_enable_bit && autoneg_forced_mode_bit) begin
         req_mode = test_pattern_control_reg[phy_test_pkg::SEL_MSB:phy_test_pkg::SEL_LSB];
      end else begin
         req_mode = phy_test_pkg::SEL_NORMAL;
      end
   end

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // All decisions live here so one registered copy holds this PHY's state.
   always_comb begin
      nxt_st = st_ff;
      pat_sym = pcs_sym;
      // Power-down sequencer: the ready flag follows a fixed settling time.
      case (st_ff.pd_state)
         phy_test_pkg::PD_RUN: begin
            if (soft_powerdown_request) begin
               nxt_st.pd_state = phy_test_pkg::PD_ENTERING;
               nxt_st.settle_cnt = 4'h0;
            end
         end
         phy_test_pkg::PD_ENTERING: begin
            if (!soft_powerdown_request) begin
               nxt_st.pd_state = phy_test_pkg::PD_RUN;
            end else if (st_ff.settle_cnt == 4'(phy_test_pkg::PD_SETTLE_CYC - 1)) begin
               nxt_st.pd_state = phy_test_pkg::PD_DOWN;
            end else begin
               nxt_st.settle_cnt = st_ff.settle_cnt + 4'h1;
            end
         end
         phy_test_pkg::PD_DOWN: begin
            if (!soft_powerdown_request) begin
               nxt_st.pd_state = phy_test_pkg::PD_RUN;
            end
         end
         default: begin
            nxt_st.pd_state = phy_test_pkg::PD_RUN;
         end
      endcase

      // Symbol path moves only on the symbol strobe, so timing stays normal.
      if (sym_strobe) begin
         // Settings are sampled only while running; a setting written during
         // power-down waits for the exit and the next symbol boundary.
         if (st_ff.pd_state == phy_test_pkg::PD_RUN) begin
            nxt_st.mode = req_mode;
            nxt_st.txdis = tx_disable_mode_bit;
         end
         if (nxt_st.mode != st_ff.mode) begin
            nxt_st.pat2_idx = 5'h0;
         end else if (st_ff.pat2_idx == PAT2_LAST) begin
            nxt_st.pat2_idx = 5'h0;
         end else begin
            nxt_st.pat2_idx = st_ff.pat2_idx + 5'h1;
         end
         case (nxt_st.mode)
            phy_test_pkg::SEL_PAT1: begin
               if (st_ff.sym == phy_test_pkg::SYM_PLUS && st_ff.mode == phy_test_pkg::SEL_PAT1) begin
                  pat_sym = phy_test_pkg::SYM_MINUS;
               end else begin
                  pat_sym = phy_test_pkg::SYM_PLUS;
               end
            end
            phy_test_pkg::SEL_PAT2: begin
               if (nxt_st.pat2_idx < phy_test_pkg::PAT2_HALF) begin
                  pat_sym = phy_test_pkg::SYM_PLUS;
               end else begin
                  pat_sym = phy_test_pkg::SYM_MINUS;
               end
            end
            default: begin
               pat_sym = pcs_sym;
            end
         endcase
         if (nxt_st.txdis || st_ff.pd_state != phy_test_pkg::PD_RUN) begin
            nxt_st.sym = phy_test_pkg::SYM_ZERO;
         end else begin
            nxt_st.sym = pat_sym;
         end
      end

      // Transmit nibble source: generator first, then loopback, then MAC.
      // Pattern three keeps the line in interframe idle.
      if (st_ff.mode == phy_test_pkg::SEL_PAT3) begin
         nxt_st.txd = 4'h0;
         nxt_st.tx_en = 1'b0;
      end else if (gen_active) begin
         nxt_st.txd = gen_txd;
         nxt_st.tx_en = gen_tx_en;
      end else if (remote_loopback_enable) begin
         nxt_st.txd = line_rxd;
         nxt_st.tx_en = line_rx_dv;
      end else begin
         nxt_st.txd = mac_txd;
         nxt_st.tx_en = mac_tx_en;
      end

      // Receive toward the MAC, held off while loopback suppresses it.
      if (remote_loopback_enable && remote_loopback_rx_suppress) begin
         nxt_st.rxd = 4'h0;
         nxt_st.rx_dv = 1'b0;
      end else begin
         nxt_st.rxd = line_rxd;
         nxt_st.rx_dv = line_rx_dv;
      end

      // Frame checker: one frame per valid burst, one error per bad frame.
      // Counters saturate rather than wrap so a long soak never reads low.
      if (checker_enable) begin
         nxt_st.in_frame = line_rx_dv;
         if (line_rx_dv) begin
            nxt_st.frame_bad = (st_ff.in_frame && st_ff.frame_bad) || line_rx_er;
         end
         if (st_ff.in_frame && !line_rx_dv) begin
            if (st_ff.frm_cnt != '1) begin
               nxt_st.frm_cnt = st_ff.frm_cnt + 1'b1;
            end
            if (st_ff.frame_bad && st_ff.err_cnt != '1) begin
               nxt_st.err_cnt = st_ff.err_cnt + 1'b1;
            end
            nxt_st.frame_bad = 1'b0;
         end
      end else begin
         nxt_st.in_frame = 1'b0;
         nxt_st.frame_bad = 1'b0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Clock enable low freezes every field, including the counters.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
         st_ff.pd_state <= phy_test_pkg::PD_RUN;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign soft_powerdown_ready_flag = (st_ff.pd_state == phy_test_pkg::PD_DOWN);
   assign mac_rxd = st_ff.rxd;
   assign mac_rx_dv = st_ff.rx_dv;
   assign pcs_txd = st_ff.txd;
   assign pcs_tx_en = st_ff.tx_en;
   assign tx_sym = st_ff.sym;
   assign active_pattern = st_ff.mode;
   assign active_tx_disable = st_ff.txdis;
   assign checker_frame_count = st_ff.frm_cnt;
   assign checker_error_count = st_ff.err_cnt;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Held request reaches the ready flag after the settling cycles.
   property p_ready_rises;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      soft_powerdown_request [*6] |-> soft_powerdown_ready_flag;
   endproperty
   a_ready_rises: assert property (p_ready_rises) else $error("ready flag late");

   property p_ready_drops;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      !soft_powerdown_request |=> !soft_powerdown_ready_flag;
   endproperty
   a_ready_drops: assert property (p_ready_drops) else $error("ready without request");

   property p_mode_on_boundary;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      (active_pattern != $past(active_pattern)) |->
         $past(sym_strobe) && $past(st_ff.pd_state == phy_test_pkg::PD_RUN);
   endproperty
   a_mode_on_boundary: assert property (p_mode_on_boundary) else $error("mode changed mid symbol");

   property p_pat1_alternates;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      (sym_strobe && active_pattern == phy_test_pkg::SEL_PAT1 && !active_tx_disable
         && st_ff.pd_state == phy_test_pkg::PD_RUN && req_mode == phy_test_pkg::SEL_PAT1
         && !tx_disable_mode_bit && tx_sym == phy_test_pkg::SYM_PLUS)
         |=> tx_sym == phy_test_pkg::SYM_MINUS;
   endproperty
   a_pat1_alternates: assert property (p_pat1_alternates) else $error("pattern one broke");

   property p_pat2_shape;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      (active_pattern == phy_test_pkg::SEL_PAT2 && !active_tx_disable
         && $past(st_ff.pd_state == phy_test_pkg::PD_RUN) && $past(sym_strobe)
         && $past(clk_en))
         |-> tx_sym == ((st_ff.pat2_idx < phy_test_pkg::PAT2_HALF) ?
             phy_test_pkg::SYM_PLUS : phy_test_pkg::SYM_MINUS);
   endproperty
   a_pat2_shape: assert property (p_pat2_shape) else $error("pattern two shape wrong");

   property p_txdis_zero;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      active_tx_disable |-> tx_sym == phy_test_pkg::SYM_ZERO;
   endproperty
   a_txdis_zero: assert property (p_txdis_zero) else $error("nonzero symbol in tx disable");

   property p_gen_wins;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      (gen_active && active_pattern != phy_test_pkg::SEL_PAT3)
         |=> pcs_txd == $past(gen_txd) && pcs_tx_en == $past(gen_tx_en);
   endproperty
   a_gen_wins: assert property (p_gen_wins) else $error("generator not on line");

   property p_loopback;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      (remote_loopback_enable && !gen_active && active_pattern != phy_test_pkg::SEL_PAT3)
         |=> pcs_txd == $past(line_rxd) && pcs_tx_en == $past(line_rx_dv);
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback frame lost");

   property p_rx_suppress;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      (remote_loopback_enable && remote_loopback_rx_suppress) |=> !mac_rx_dv;
   endproperty
   a_rx_suppress: assert property (p_rx_suppress) else $error("suppressed frame reached mac");

   property p_frame_count;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      (checker_enable && st_ff.in_frame && !line_rx_dv && checker_frame_count != '1)
         |=> checker_frame_count == $past(checker_frame_count) + 1'b1;
   endproperty
   a_frame_count: assert property (p_frame_count) else $error("frame not counted");

   property p_pat3_idle;
      @(posedge clk) disable iff (!reset_n || !clk_en)
      active_pattern == phy_test_pkg::SEL_PAT3 |=> !pcs_tx_en;
   endproperty
   a_pat3_idle: assert property (p_pat3_idle) else $error("frame sent in pattern three");

endmodule

// ---- dv/remote_phy_model.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Remote PHY at the far end of the cable
// ****************************************************************
module remote_phy_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic echo_en,
   input wire logic err_en,
   input wire logic inj_dv,
   input wire logic [3:0] inj_d,
   input wire logic [3:0] tx_d,
   input wire logic tx_en,
   output logic [3:0] rx_d,
   output logic rx_dv,
   output logic rx_er
);
   logic v;
   logic [3:0] d;

   // In echo mode the far end returns every frame it hears; otherwise it sends bench data.
   assign v = echo_en ? tx_en : inj_dv;
   assign d = echo_en ? tx_d : inj_d;

   // Idle nibbles toggle so that a stale nibble never passes for frame data.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_d <= 4'h0;
         rx_dv <= 1'b0;
         rx_er <= 1'b0;
      end else begin
         rx_dv <= v;
         rx_d <= v ? d : ~rx_d;
         rx_er <= v & err_en;
      end
   end
endmodule

// ---- dv/phy_test_mode_and_link_selftest_test.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Test bench for the test mode and link self test block
// ****************************************************************
module phy_test_mode_and_link_selftest_test;
   logic clk, reset_n, sd_req, ready, aneg, ce, frc, txdis, lb_en, lb_sup, gen_act, gen_en;
   logic mac_en, strobe, chk_en, echo, err, inj_dv, rx_dv, tx_en, act_dis, l_dv, l_er, seen;
   logic [15:0] ctrl, frames, errs;
   logic [3:0] gen_d, mac_d, inj_d, rxd, txd, l_d;
   logic [1:0] psym, sym;
   logic [2:0] act_pat;
   logic [1:0] tbl [3] = '{phy_test_pkg::SYM_PLUS, phy_test_pkg::SYM_MINUS, 2'h0};
   int n_fail = 0;
   int num_checks = 0;
   int i;

   phy_test_mode i_phy_test_mode (.clk(clk), .reset_n(reset_n), .clk_en(ce),
      .soft_powerdown_request(sd_req), .soft_powerdown_ready_flag(ready),
      .autoneg_enable_bit(aneg), .autoneg_forced_mode_bit(frc),
      .test_pattern_control_reg(ctrl), .tx_disable_mode_bit(txdis),
      .remote_loopback_enable(lb_en), .remote_loopback_rx_suppress(lb_sup),
      .gen_active(gen_act), .gen_txd(gen_d), .gen_tx_en(gen_en), .mac_txd(mac_d),
      .mac_tx_en(mac_en), .line_rxd(l_d), .line_rx_dv(l_dv), .line_rx_er(l_er),
      .mac_rxd(rxd), .mac_rx_dv(rx_dv), .pcs_txd(txd), .pcs_tx_en(tx_en),
      .sym_strobe(strobe), .pcs_sym(psym), .tx_sym(sym), .active_pattern(act_pat),
      .active_tx_disable(act_dis), .checker_enable(chk_en),
      .checker_frame_count(frames), .checker_error_count(errs));

   remote_phy_model i_remote_phy_model (.clk(clk), .reset_n(reset_n), .echo_en(echo),
      .err_en(err), .inj_dv(inj_dv), .inj_d(inj_d), .tx_d(txd), .tx_en(tx_en),
      .rx_d(l_d), .rx_dv(l_dv), .rx_er(l_er));

   // The clock runs at 40 MHz.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic results;
      if (n_fail == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Outputs are read 1 ns after the edge so that the edge's updates have landed.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_ready(input logic v);
      for (int k = 0; k < 20 && ready !== v; k++) tick(1);
      if (ready !== v) begin
         n_fail++;
         results();
      end
   endtask

   task automatic sym_chk(input logic [1:0] s, input logic [1:0] exp);
      @(posedge clk);
      strobe <= 1'b1;
      psym <= s;
      @(posedge clk);
      strobe <= 1'b0;
      #1;
      chk("tx_sym", {14'h0, exp}, {14'h0, sym});
   endtask

   // Host entry sequence; the old mode must hold until the first strobe after release.
   task automatic enter(input logic [2:0] sel, input logic dis, input logic [2:0] old);
      @(posedge clk);
      sd_req <= 1'b1;
      wait_ready(1'b1);
      @(posedge clk);
      aneg <= 1'b0;
      frc <= 1'b1;
      ctrl <= {sel, 13'h1FFF};
      txdis <= dis;
      sym_chk(2'h1, 2'h0);
      chk("active_pattern", old, act_pat);
      @(posedge clk);
      sd_req <= 1'b0;
      wait_ready(1'b0);
      chk("active_pattern", old, act_pat);
   endtask

   // Generator frame of four nibbles, echoed by the far end.
   task automatic send_frame(input logic e);
      @(posedge clk);
      err <= e;
      gen_en <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         gen_d <= 4'(k + 1);
         @(posedge clk);
      end
      gen_en <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   // A hang is cut short well inside the cycle budget.
   initial begin
      #250000;
      n_fail++;
      results();
   end

   // Main sequence.
   initial begin
      {reset_n, sd_req, frc, txdis, lb_en, gen_act, gen_en, strobe, chk_en} = '0;
      {echo, err, inj_dv, seen, ctrl, gen_d, inj_d, psym} = '0;
      {aneg, lb_sup, mac_en, ce} = 4'hF;
      mac_d = 4'hA;
      tick(3);
      chk("ready", 0, ready);
      chk("tx_sym", 0, sym);
      @(posedge clk) reset_n <= 1'b1;
      tick(2);
      chk("pcs_txd", 4'hA, txd);
      @(posedge clk) sd_req <= 1'b1;
      tick(phy_test_pkg::PD_SETTLE_CYC);
      chk("ready", 0, ready);
      tick(1);
      chk("ready", 1, ready);
      @(posedge clk) sd_req <= 1'b0;
      tick(2);
      chk("ready", 0, ready);
      @(posedge clk) sd_req <= 1'b1;
      tick(3);
      @(posedge clk) sd_req <= 1'b0;
      for (i = 0; i < 8; i++) begin
         tick(1);
         seen = seen | ready;
      end
      chk("ready", 0, seen);
      enter(phy_test_pkg::SEL_PAT1, 1'b0, phy_test_pkg::SEL_NORMAL);
      for (i = 0; i < 6; i++) sym_chk(2'h0, tbl[i % 2]);
      // Clock enable low must freeze the pattern, so minus one stays on the line.
      @(posedge clk) ce <= 1'b0;
      sym_chk(2'h0, phy_test_pkg::SYM_MINUS);
      @(posedge clk) ce <= 1'b1;
      enter(phy_test_pkg::SEL_PAT2, 1'b0, phy_test_pkg::SEL_PAT1);
      for (i = 0; i < 40; i++) sym_chk(2'h0, tbl[(i % 20) / 10]);
      chk("active_pattern", phy_test_pkg::SEL_PAT2, act_pat);
      enter(phy_test_pkg::SEL_PAT3, 1'b0, phy_test_pkg::SEL_PAT2);
      for (i = 0; i < 3; i++) sym_chk(tbl[i], tbl[i]);
      tick(1);
      chk("pcs_tx_en", 0, tx_en);
      enter(phy_test_pkg::SEL_NORMAL, 1'b1, phy_test_pkg::SEL_PAT3);
      for (i = 0; i < 3; i++) sym_chk(tbl[i], 2'h0);
      chk("active_tx_disable", 1, act_dis);
      @(posedge clk);
      lb_en <= 1'b1;
      inj_dv <= 1'b1;
      inj_d <= 4'h9;
      tick(2);
      chk("pcs_txd", 4'h9, txd);
      chk("mac_rx_dv", 0, rx_dv);
      @(posedge clk) lb_sup <= 1'b0;
      tick(1);
      chk("mac_rxd", 4'h9, rxd);
      chk("mac_rx_dv", 1, rx_dv);
      @(posedge clk);
      gen_act <= 1'b1;
      gen_en <= 1'b1;
      gen_d <= 4'h5;
      tick(1);
      chk("pcs_txd", 4'h5, txd);
      @(posedge clk);
      {inj_dv, lb_en, gen_en} <= 3'h0;
      echo <= 1'b1;
      // The checker starts only once the injected burst has drained from the line.
      repeat (4) @(posedge clk);
      chk_en <= 1'b1;
      send_frame(1'b0);
      send_frame(1'b1);
      tick(2);
      chk("frames", 2, frames);
      chk("errors", 1, errs);
      results();
   end
endmodule
